/* sim/pci_far_agent.sv */
/*
 * far side of the pci bus when the port masters: arbiter grant and an
 * addressed target that completes, retries, aborts or never answers.
 * assumes control lines float high through pull-ups when released.
 */
module pci_far_agent (
    input wire logic sys_clk,
    input wire logic req_l,
    input wire logic frame_l,
    input wire logic irdy_l,
    input wire logic [1:0] mode,
    output logic gnt_l,
    output logic devsel_l,
    output logic trdy_l,
    output logic stop_l
);
    timeunit 1ns;
    timeprecision 100ps;
    int step = 0; // cycles since our granted address phase, 0 when idle
    logic granted = 1'b0; // grant was low at the previous edge
    initial begin
        gnt_l = 1'b1;
        devsel_l = 1'b1;
        trdy_l = 1'b1;
        stop_l = 1'b1;
    end
    // sample at the edge, drive just after it
    always @(posedge sys_clk) begin
        if (step == 0) begin
            // the master starts frame one clock after it sampled the grant
            if (!frame_l && granted) begin
                step = 1;
            end
        end else if ((!irdy_l && (!trdy_l || !stop_l)) || (step > 2 && frame_l && irdy_l)) begin
            step = 0;
        end else begin
            step = step + 1;
        end
        granted = !gnt_l;
        #2;
        gnt_l = req_l;
        devsel_l = !(step >= 2 && mode != 2'h3 && (mode != 2'h2 || step == 2));
        trdy_l = !(step >= 3 && mode == 2'h0);
        stop_l = !(step >= 3 && (mode == 2'h1 || mode == 2'h2));
    end
endmodule // pci_far_agent

/* sim/pci_port_command_handshake_bench.sv */
/*
 * self-checking bench: target claim per command, serr timing, rom select
 * and master transfers against the far agent.
 * assumes pins resolve from enables, released lines pulled high.
 */
module pci_port_command_handshake_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic sys_clk = 0, rstn = 0, idsel = 1, tgt_rdy = 1, sig_sys_err_clr = 0;
    logic rom_access = 0, mst_start = 0, mst_write = 0, b_frame = 1, b_irdy = 1, b_par = 0;
    logic [31:0] tgt_rdata = 32'hfeed_0042, mst_addr = 32'h0000_4000;
    logic [31:0] mst_wdata = 32'h1357_9bdf, b_ad = 32'h0000_1230;
    logic [15:0] csw_cmd = 16'h0003;
    logic [3:0] b_cbe = 4'hf, adr_cbe = 4'h0, pcb = 4'h0;
    logic [1:0] mode = 2'h0;
    logic req_l_r, frame_l_r, frame_oe_r, irdy_l_r, irdy_oe_r, devsel_l_r, devsel_oe_r;
    logic trdy_l_r, trdy_oe_r, stop_l_r, stop_oe_r, ad_oe_r, cbe_oe_r, par_r, par_oe_r;
    logic serr_l_r, serr_oe_r, sig_sys_err_r, serial_rom_select_r, tgt_req_r, tgt_done_r;
    logic mst_busy_r, mst_done_r, gnt_l, p_devsel, p_trdy, p_stop;
    logic [31:0] ad_r, tgt_addr_r, tgt_wdata_r, mst_rdata_r, pad = 32'h0;
    logic [3:0] cbe_r, tgt_cmd_r, tgt_be_r;
    logic [1:0] mst_status_r;
    int fail_count = 0, n_compared = 0, cyc = 0, serr_at = 0, addr_at = 0;
    logic seen;
    // resolved pins
    wire logic frame_l = frame_oe_r ? frame_l_r : b_frame;
    wire logic irdy_l = irdy_oe_r ? irdy_l_r : b_irdy;
    wire logic devsel_l = (devsel_oe_r ? devsel_l_r : 1'b1) & p_devsel;
    wire logic trdy_l = (trdy_oe_r ? trdy_l_r : 1'b1) & p_trdy;
    wire logic stop_l = (stop_oe_r ? stop_l_r : 1'b1) & p_stop;
    wire logic par = par_oe_r ? par_r : b_par;
    wire logic [31:0] ad = ad_oe_r ? ad_r : b_ad;
    wire logic [3:0] c_be_l = cbe_oe_r ? cbe_r : b_cbe;
    // cases: {command, claimed}
    localparam logic [4:0] ROWS [16] = '{5'h00, 5'h02, 5'h05, 5'h07, 5'h08, 5'h0a, 5'h0d,
        5'h0f, 5'h10, 5'h12, 5'h15, 5'h17, 5'h18, 5'h1a, 5'h1c, 5'h1e};
    pci_port_command_handshake dut (.*);
    pci_far_agent far (.sys_clk(sys_clk), .req_l(req_l_r), .frame_l(frame_l), .irdy_l(irdy_l),
        .mode(mode), .gnt_l(gnt_l), .devsel_l(p_devsel), .trdy_l(p_trdy), .stop_l(p_stop));
    always #12.5 sys_clk = ~sys_clk;
    task automatic chk_bit(input string nm, input logic e, input logic g);
        n_compared++;
        if (g !== e) begin
            fail_count++;
            $display("mismatch %s expected %b seen %b", nm, e, g);
        end
    endtask
    task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    // per-edge watch: serr moment, parity, address command, write data
    always @(posedge sys_clk) begin
        cyc++;
        if (serr_oe_r === 1'b1) serr_at = cyc;
        if (par_oe_r === 1'b1) chk_bit("par", ^{pad, pcb}, par_r);
        if (irdy_oe_r === 1'b1 && irdy_l_r === 1'b0 && mst_write) begin
            chk_bit("ad_oe", 1'b1, ad_oe_r);
            chk_word("wdata", mst_wdata, ad_r);
        end
        if (frame_oe_r === 1'b1 && frame_l_r === 1'b0) adr_cbe <= cbe_r;
        pad <= ad_r;
        pcb <= c_be_l;
    end
    // one single-phase transfer mastered by the bench
    task automatic tgt_cycle(input logic [3:0] cmd, input logic bad);
        seen = 0;
        b_frame = 0;
        b_cbe = cmd;
        @(posedge sys_clk) #2;
        addr_at = cyc;
        b_par = ^{b_ad, cmd} ^ bad;
        b_frame = 1;
        b_irdy = 0;
        b_cbe = 4'h0;
        for (int k = 0; k < 8; k++) begin
            @(posedge sys_clk);
            if (devsel_oe_r === 1'b1) seen = 1;
            if (trdy_l === 1'b0) begin
                if (!cmd[0]) chk_word("rd_ad", tgt_rdata, ad);
                break;
            end
        end
        #2 b_irdy = 1;
        repeat (3) @(posedge sys_clk);
        #2;
    endtask
    task automatic mst_run(input logic wr, input logic [1:0] md);
        int k;
        mode = md;
        mst_write = wr;
        mst_start = 1;
        @(posedge sys_clk) #2;
        mst_start = 0;
        chk_bit("busy", 1'b1, mst_busy_r);
        for (k = 0; k < 40 && mst_done_r !== 1'b1; k++) @(posedge sys_clk) #2;
        chk_word("status", {30'h0, md}, {30'h0, mst_status_r});
        chk_word("cmd", wr ? 32'h7 : 32'h6, {28'h0, adr_cbe});
        if (!wr && md == 2'h0) chk_word("rdata", b_ad, mst_rdata_r);
        repeat (3) @(posedge sys_clk) #2;
        chk_bit("idle", 1'b0, mst_busy_r);
    endtask
    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        #500000;
        fail_count++;
        conclude();
    end
    initial begin
        repeat (8) @(posedge sys_clk);
        #2 rstn = 1;
        chk_bit("req_l", 1'b1, req_l_r);
        chk_bit("devsel_oe", 1'b0, devsel_oe_r);
        $display("test reset done");
        foreach (ROWS[i]) begin
            tgt_cycle(ROWS[i][4:1], 1'b0);
            chk_bit("claim", ROWS[i][0], seen);
            if (ROWS[i][0]) chk_word("tgt_cmd", {28'h0, ROWS[i][4:1]}, {28'h0, tgt_cmd_r});
            if (ROWS[i][0]) chk_word("tgt_addr", b_ad, tgt_addr_r);
            if (ROWS[i][0] && ROWS[i][1]) chk_word("tgt_wdata", b_ad, tgt_wdata_r);
        end
        $display("test command rows done");
        csw_cmd = 16'h0103;
        tgt_cycle(4'h6, 1'b1);
        chk_word("serr_delay", 32'h2, serr_at - addr_at);
        chk_bit("sig_err", 1'b1, sig_sys_err_r);
        sig_sys_err_clr = 1;
        @(posedge sys_clk) #2;
        sig_sys_err_clr = 0;
        csw_cmd = 16'h0003;
        serr_at = 0;
        tgt_cycle(4'h6, 1'b1);
        chk_word("serr_off", 32'h0, serr_at);
        chk_bit("sig_off", 1'b0, sig_sys_err_r);
        $display("test serr done");
        rom_access = 1;
        @(posedge sys_clk) #2;
        chk_bit("rom_on", 1'b1, serial_rom_select_r);
        rom_access = 0;
        @(posedge sys_clk) #2;
        chk_bit("rom_off", 1'b0, serial_rom_select_r);
        $display("test rom select done");
        csw_cmd = 16'h0007;
        b_ad = 32'h5a5a_0f0f;
        for (int m = 0; m < 8; m++) mst_run(m[0], m[2:1]);
        $display("test master done");
        conclude();
    end
endmodule // pci_port_command_handshake_bench

/* src/pci_cmd_pkg.sv */
/*
 * constants, state encodings and shared functions for the pci port
 * command and handshake logic.
 * assumes every bus pin is sampled on the same pci clock as the logic.
 */
package pci_cmd_pkg;

    // bus command codes on c_be_l during the address phase
    localparam logic [3:0] CMD_INT_ACK = 4'h0;
    localparam logic [3:0] CMD_SPECIAL = 4'h1;
    localparam logic [3:0] CMD_IO_RD = 4'h2;
    localparam logic [3:0] CMD_IO_WR = 4'h3;
    localparam logic [3:0] CMD_MEM_RD = 4'h6;
    localparam logic [3:0] CMD_MEM_WR = 4'h7;
    localparam logic [3:0] CMD_CFG_RD = 4'ha;
    localparam logic [3:0] CMD_CFG_WR = 4'hb;
    localparam logic [3:0] CMD_MWI = 4'hd;
    localparam logic [3:0] CMD_MEM_RD_LONG = 4'he;
    localparam logic [3:0] CMD_POST_WR = 4'hf;

    // bit positions in the command half of the command/status word
    localparam int CSW_IO_EN_BIT = 0;
    localparam int CSW_MEM_EN_BIT = 1;
    localparam int CSW_MASTER_EN_BIT = 2;
    localparam int CSW_SERR_EN_BIT = 8;
    // status bit that the system error flag stands for
    localparam int CSW_SIG_SERR_BIT = 30;

    // clocks without devsel before the master gives up (master abort)
    localparam logic [2:0] DEVSEL_TIMEOUT = 3'h5;
    // byte enables used by the master data phase (all lanes)
    localparam logic [3:0] BE_ALL = 4'h0;
    // reset values of driven pin levels
    localparam logic PIN_IDLE = 1'b1;
    localparam logic [31:0] AD_RESET = 32'h0000_0000;

    // master termination codes
    localparam logic [1:0] MST_OK = 2'h0;
    localparam logic [1:0] MST_RETRY = 2'h1;
    localparam logic [1:0] MST_TABORT = 2'h2;
    localparam logic [1:0] MST_MABORT = 2'h3;

    typedef enum logic [4:0] {
        M_IDLE = 5'h01,
        M_REQ = 5'h02,
        M_ADDR = 5'h04,
        M_DATA = 5'h08,
        M_TURN = 5'h10
    } mst_state_e;

    typedef enum logic [3:0] {
        T_IDLE = 4'h1,
        T_DEC = 4'h2,
        T_DATA = 4'h4,
        T_TURN = 4'h8
    } tgt_state_e;

    // even parity over ad and c_be_l
    function automatic logic even_parity(input logic [31:0] a, input logic [3:0] c);
        even_parity = ^{a, c};
    endfunction

    // true for commands this port claims as a target
    function automatic logic target_cmd_ok(input logic [3:0] cmd, input logic sel,
                                           input logic [15:0] csw);
        case (cmd)
            CMD_IO_RD, CMD_IO_WR: target_cmd_ok = csw[CSW_IO_EN_BIT];
            CMD_MEM_RD, CMD_MEM_WR: target_cmd_ok = csw[CSW_MEM_EN_BIT];
            CMD_CFG_RD, CMD_CFG_WR: target_cmd_ok = sel;
            default: target_cmd_ok = 1'b0;
        endcase
    endfunction

endpackage

/* src/pci_par_gen.sv */
/*
 * parity generator for the driven ad/c_be_l lines.
 * assumes par follows the lines it covers by one clock, and is driven
 * whenever this port drives ad.
 */
module pci_par_gen (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [31:0] ad_val,
    input wire logic [3:0] cbe_val,
    input wire logic ad_drv,
    output logic par_r,
    output logic par_oe_r
);

    logic par_nxt;
    logic par_oe_nxt;

    // parity one clock behind the lines, driven with them
    always_comb begin
        par_nxt = pci_cmd_pkg::even_parity(ad_val, cbe_val);
        par_oe_nxt = ad_drv;
    end

    // register parity and its enable
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            par_r <= 1'b0;
            par_oe_r <= 1'b0;
        end else begin
            par_r <= par_nxt;
            par_oe_r <= par_oe_nxt;
        end
    end

endmodule // pci_par_gen

/* src/pci_port_command_handshake.sv */
/*
 * pci port command decode and handshake logic: target claim, master
 * single-phase memory transfers, address parity check with system error,
 * parity generation and serial rom select.
 * assumes all bus pins are synchronous to sys_clk (the pci clock) and
 * that pins are resolved outside from the output enables.
 */
module pci_port_command_handshake (
    input wire logic sys_clk,
    input wire logic rstn,
    // bus pins, sampled directly
    input wire logic frame_l,
    input wire logic irdy_l,
    input wire logic trdy_l,
    input wire logic stop_l,
    input wire logic devsel_l,
    input wire logic gnt_l,
    input wire logic idsel,
    input wire logic par,
    input wire logic [31:0] ad,
    input wire logic [3:0] c_be_l,
    // bus drive
    output logic req_l_r,
    output logic frame_l_r,
    output logic frame_oe_r,
    output logic irdy_l_r,
    output logic irdy_oe_r,
    output logic devsel_l_r,
    output logic devsel_oe_r,
    output logic trdy_l_r,
    output logic trdy_oe_r,
    output logic stop_l_r,
    output logic stop_oe_r,
    output logic [31:0] ad_r,
    output logic ad_oe_r,
    output logic [3:0] cbe_r,
    output logic cbe_oe_r,
    output logic par_r,
    output logic par_oe_r,
    output logic serr_l_r,
    output logic serr_oe_r,
    // command half of the command/status word, status flag
    input wire logic [15:0] csw_cmd,
    input wire logic sig_sys_err_clr,
    output logic sig_sys_err_r,
    // serial rom
    input wire logic rom_access,
    output logic serial_rom_select_r,
    // target user side
    input wire logic tgt_rdy,
    input wire logic [31:0] tgt_rdata,
    output logic tgt_req_r,
    output logic [3:0] tgt_cmd_r,
    output logic [31:0] tgt_addr_r,
    output logic tgt_done_r,
    output logic [31:0] tgt_wdata_r,
    output logic [3:0] tgt_be_r,
    // master user side
    input wire logic mst_start,
    input wire logic mst_write,
    input wire logic [31:0] mst_addr,
    input wire logic [31:0] mst_wdata,
    output logic mst_busy_r,
    output logic mst_done_r,
    output logic [1:0] mst_status_r,
    output logic [31:0] mst_rdata_r
);

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    logic frame_prev_r; // frame_l one clock ago
    logic addr_phase; // first clock of a transaction from another master
    logic t_ok; // command is claimable

    assign addr_phase = !frame_l && frame_prev_r && !frame_oe_r;
    assign t_ok = pci_cmd_pkg::target_cmd_ok(c_be_l, idsel, csw_cmd);

    // ---------------- master ----------------
    pci_cmd_pkg::mst_state_e m_state_r, m_state_nxt;
    logic mst_wr_r, mst_wr_nxt;
    logic [31:0] m_addr_r, m_addr_nxt, m_wdata_r, m_wdata_nxt;
    logic [2:0] m_cnt_r, m_cnt_nxt; // clocks waited in data phase
    logic req_l_nxt, frame_l_nxt, frame_oe_nxt, irdy_l_nxt, irdy_oe_nxt;
    logic [3:0] cbe_nxt;
    logic cbe_oe_nxt, mst_done_nxt, mst_busy_nxt;
    logic [1:0] mst_status_nxt;
    logic [31:0] mst_rdata_nxt;
    logic m_ad_drv; // master drives ad next clock
    logic [31:0] m_ad_val;

    // master sequencer: request, address, one data phase, turnaround
    always_comb begin
        m_state_nxt = m_state_r;
        mst_wr_nxt = mst_wr_r;
        m_addr_nxt = m_addr_r;
        m_wdata_nxt = m_wdata_r;
        m_cnt_nxt = m_cnt_r;
        req_l_nxt = req_l_r;
        frame_l_nxt = frame_l_r;
        frame_oe_nxt = frame_oe_r;
        irdy_l_nxt = irdy_l_r;
        irdy_oe_nxt = irdy_oe_r;
        cbe_nxt = cbe_r;
        cbe_oe_nxt = cbe_oe_r;
        mst_done_nxt = 1'b0;
        mst_status_nxt = mst_status_r;
        mst_rdata_nxt = mst_rdata_r;
        m_ad_drv = 1'b0;
        m_ad_val = m_wdata_r;
        case (m_state_r)
            pci_cmd_pkg::M_IDLE: begin
                // start only when bus mastering is enabled
                if (mst_start && csw_cmd[pci_cmd_pkg::CSW_MASTER_EN_BIT]) begin
                    mst_wr_nxt = mst_write;
                    m_addr_nxt = mst_addr;
                    m_wdata_nxt = mst_wdata;
                    req_l_nxt = 1'b0;
                    m_state_nxt = pci_cmd_pkg::M_REQ;
                end
            end
            pci_cmd_pkg::M_REQ: begin
                // granted and bus idle: address phase
                if (!gnt_l && frame_l && irdy_l) begin
                    req_l_nxt = 1'b1;
                    frame_l_nxt = 1'b0;
                    frame_oe_nxt = 1'b1;
                    cbe_oe_nxt = 1'b1;
                    cbe_nxt = mst_wr_r ? pci_cmd_pkg::CMD_MEM_WR : pci_cmd_pkg::CMD_MEM_RD;
                    m_ad_drv = 1'b1;
                    m_ad_val = m_addr_r;
                    m_state_nxt = pci_cmd_pkg::M_ADDR;
                end
            end
            pci_cmd_pkg::M_ADDR: begin
                // single data phase, so frame ends here
                frame_l_nxt = 1'b1;
                cbe_nxt = pci_cmd_pkg::BE_ALL;
                irdy_oe_nxt = 1'b1;
                // irdy with write data, or ready to take read data
                irdy_l_nxt = 1'b0;
                m_ad_drv = mst_wr_r;
                m_cnt_nxt = 3'h0;
                m_state_nxt = pci_cmd_pkg::M_DATA;
            end
            pci_cmd_pkg::M_DATA: begin
                m_ad_drv = mst_wr_r;
                m_cnt_nxt = m_cnt_r + 3'h1;
                // completes only with trdy and irdy together
                if (!trdy_l) begin
                    mst_status_nxt = pci_cmd_pkg::MST_OK;
                    mst_rdata_nxt = ad;
                    mst_done_nxt = 1'b1;
                end else if (!stop_l) begin
                    // stop without data: retry or target abort
                    mst_status_nxt = devsel_l ? pci_cmd_pkg::MST_TABORT
                                              : pci_cmd_pkg::MST_RETRY;
                    mst_done_nxt = 1'b1;
                end else if (devsel_l && m_cnt_r == pci_cmd_pkg::DEVSEL_TIMEOUT) begin
                    mst_status_nxt = pci_cmd_pkg::MST_MABORT;
                    mst_done_nxt = 1'b1;
                end
                if (mst_done_nxt) begin
                    m_ad_drv = 1'b0;
                    irdy_l_nxt = 1'b1;
                    frame_oe_nxt = 1'b0;
                    cbe_oe_nxt = 1'b0;
                    m_state_nxt = pci_cmd_pkg::M_TURN;
                end
            end
            pci_cmd_pkg::M_TURN: begin
                // irdy was driven high one clock, now release it
                irdy_oe_nxt = 1'b0;
                m_state_nxt = pci_cmd_pkg::M_IDLE;
            end
            default: begin
                m_state_nxt = pci_cmd_pkg::M_IDLE;
            end
        endcase
        mst_busy_nxt = (m_state_nxt != pci_cmd_pkg::M_IDLE);
    end

    // master registers
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            m_state_r <= pci_cmd_pkg::M_IDLE;
            mst_wr_r <= 1'b0;
            m_addr_r <= pci_cmd_pkg::AD_RESET;
            m_wdata_r <= pci_cmd_pkg::AD_RESET;
            m_cnt_r <= 3'h0;
            req_l_r <= pci_cmd_pkg::PIN_IDLE;
            frame_l_r <= pci_cmd_pkg::PIN_IDLE;
            frame_oe_r <= 1'b0;
            irdy_l_r <= pci_cmd_pkg::PIN_IDLE;
            irdy_oe_r <= 1'b0;
            cbe_r <= 4'h0;
            cbe_oe_r <= 1'b0;
            mst_done_r <= 1'b0;
            mst_busy_r <= 1'b0;
            mst_status_r <= pci_cmd_pkg::MST_OK;
            mst_rdata_r <= pci_cmd_pkg::AD_RESET;
        end else begin
            m_state_r <= m_state_nxt;
            mst_wr_r <= mst_wr_nxt;
            m_addr_r <= m_addr_nxt;
            m_wdata_r <= m_wdata_nxt;
            m_cnt_r <= m_cnt_nxt;
            req_l_r <= req_l_nxt;
            frame_l_r <= frame_l_nxt;
            frame_oe_r <= frame_oe_nxt;
            irdy_l_r <= irdy_l_nxt;
            irdy_oe_r <= irdy_oe_nxt;
            cbe_r <= cbe_nxt;
            cbe_oe_r <= cbe_oe_nxt;
            mst_done_r <= mst_done_nxt;
            mst_busy_r <= mst_busy_nxt;
            mst_status_r <= mst_status_nxt;
            mst_rdata_r <= mst_rdata_nxt;
        end
    end

    // ---------------- target ----------------
    pci_cmd_pkg::tgt_state_e t_state_r, t_state_nxt;
    logic devsel_l_nxt, devsel_oe_nxt, trdy_l_nxt, trdy_oe_nxt, stop_oe_nxt;
    logic tgt_req_nxt, tgt_done_nxt;
    logic [3:0] tgt_cmd_nxt, tgt_be_nxt;
    logic [31:0] tgt_addr_nxt, tgt_wdata_nxt;
    logic t_ad_drv; // target drives read data next clock

    // target sequencer: decode, medium devsel, data phases, turnaround
    always_comb begin
        t_state_nxt = t_state_r;
        devsel_l_nxt = devsel_l_r;
        devsel_oe_nxt = devsel_oe_r;
        trdy_l_nxt = trdy_l_r;
        trdy_oe_nxt = trdy_oe_r;
        stop_oe_nxt = stop_oe_r;
        tgt_req_nxt = 1'b0;
        tgt_done_nxt = 1'b0;
        tgt_cmd_nxt = tgt_cmd_r;
        tgt_addr_nxt = tgt_addr_r;
        tgt_be_nxt = tgt_be_r;
        tgt_wdata_nxt = tgt_wdata_r;
        t_ad_drv = 1'b0;
        case (t_state_r)
            pci_cmd_pkg::T_IDLE: begin
                if (addr_phase && t_ok) begin
                    tgt_cmd_nxt = c_be_l;
                    tgt_addr_nxt = ad;
                    t_state_nxt = pci_cmd_pkg::T_DEC;
                end
            end
            pci_cmd_pkg::T_DEC: begin
                devsel_l_nxt = 1'b0;
                devsel_oe_nxt = 1'b1;
                trdy_l_nxt = 1'b1;
                trdy_oe_nxt = 1'b1;
                stop_oe_nxt = 1'b1;
                tgt_req_nxt = 1'b1;
                t_state_nxt = pci_cmd_pkg::T_DATA;
            end
            pci_cmd_pkg::T_DATA: begin
                t_ad_drv = !tgt_cmd_r[0];
                // phase done when our trdy meets irdy
                if (!trdy_l_r && !irdy_l) begin
                    tgt_done_nxt = 1'b1;
                    tgt_wdata_nxt = ad;
                    tgt_be_nxt = c_be_l;
                    trdy_l_nxt = 1'b1;
                    if (frame_l) begin
                        devsel_l_nxt = 1'b1;
                        t_ad_drv = 1'b0;
                        t_state_nxt = pci_cmd_pkg::T_TURN;
                    end
                end else if (tgt_rdy) begin
                    trdy_l_nxt = 1'b0;
                end
            end
            pci_cmd_pkg::T_TURN: begin
                devsel_oe_nxt = 1'b0;
                trdy_oe_nxt = 1'b0;
                stop_oe_nxt = 1'b0;
                t_state_nxt = pci_cmd_pkg::T_IDLE;
            end
            default: begin
                t_state_nxt = pci_cmd_pkg::T_IDLE;
            end
        endcase
    end

    // target registers; stop is only ever driven high
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            t_state_r <= pci_cmd_pkg::T_IDLE;
            devsel_l_r <= pci_cmd_pkg::PIN_IDLE;
            devsel_oe_r <= 1'b0;
            trdy_l_r <= pci_cmd_pkg::PIN_IDLE;
            trdy_oe_r <= 1'b0;
            stop_l_r <= pci_cmd_pkg::PIN_IDLE;
            stop_oe_r <= 1'b0;
            tgt_req_r <= 1'b0;
            tgt_done_r <= 1'b0;
            tgt_cmd_r <= 4'h0;
            tgt_addr_r <= pci_cmd_pkg::AD_RESET;
            tgt_be_r <= 4'h0;
            tgt_wdata_r <= pci_cmd_pkg::AD_RESET;
        end else begin
            t_state_r <= t_state_nxt;
            devsel_l_r <= devsel_l_nxt;
            devsel_oe_r <= devsel_oe_nxt;
            trdy_l_r <= trdy_l_nxt;
            trdy_oe_r <= trdy_oe_nxt;
            stop_l_r <= pci_cmd_pkg::PIN_IDLE;
            stop_oe_r <= stop_oe_nxt;
            tgt_req_r <= tgt_req_nxt;
            tgt_done_r <= tgt_done_nxt;
            tgt_cmd_r <= tgt_cmd_nxt;
            tgt_addr_r <= tgt_addr_nxt;
            tgt_be_r <= tgt_be_nxt;
            tgt_wdata_r <= tgt_wdata_nxt;
        end
    end

    // ---------------- ad lines, parity check, serr, rom ----------------
    logic [31:0] ad_nxt;
    logic ad_oe_nxt;
    logic ap_pend_r, ap_pend_nxt, ap_exp_r, ap_exp_nxt;
    logic serr_oe_nxt, sig_sys_err_nxt, ap_err;

    always_comb begin
        // ad owner: master first, then target read data
        ad_nxt = ad_r;
        ad_oe_nxt = m_ad_drv || t_ad_drv;
        if (m_ad_drv) begin
            ad_nxt = m_ad_val;
        end else if (t_ad_drv) begin
            ad_nxt = tgt_rdata;
        end
        // address parity arrives one clock after the address
        ap_pend_nxt = addr_phase;
        ap_exp_nxt = addr_phase ? pci_cmd_pkg::even_parity(ad, c_be_l) : ap_exp_r;
        ap_err = ap_pend_r && (par != ap_exp_r);
        // serr low for one clock, visible two clocks after address
        serr_oe_nxt = ap_err && csw_cmd[pci_cmd_pkg::CSW_SERR_EN_BIT];
        // status flag: a new error wins over a clear in the same clock
        sig_sys_err_nxt = serr_oe_nxt || (sig_sys_err_r && !sig_sys_err_clr);
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ad_r <= pci_cmd_pkg::AD_RESET;
            ad_oe_r <= 1'b0;
            frame_prev_r <= pci_cmd_pkg::PIN_IDLE;
            ap_pend_r <= 1'b0;
            ap_exp_r <= 1'b0;
            serr_l_r <= 1'b0;
            serr_oe_r <= 1'b0;
            sig_sys_err_r <= 1'b0;
            serial_rom_select_r <= 1'b0;
        end else begin
            ad_r <= ad_nxt;
            ad_oe_r <= ad_oe_nxt;
            frame_prev_r <= frame_l;
            ap_pend_r <= ap_pend_nxt;
            ap_exp_r <= ap_exp_nxt;
            serr_l_r <= 1'b0;
            serr_oe_r <= serr_oe_nxt;
            sig_sys_err_r <= sig_sys_err_nxt;
            serial_rom_select_r <= rom_access;
        end
    end

    // parity covers c_be_l as on the bus, ours or the master's
    logic [3:0] par_cbe;
    assign par_cbe = cbe_oe_r ? cbe_r : c_be_l;

    // parity whenever this port drives ad
    pci_par_gen u_par (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .ad_val(ad_r),
        .cbe_val(par_cbe),
        .ad_drv(ad_oe_r),
        .par_r(par_r),
        .par_oe_r(par_oe_r)
    );

    // ---------------- checks ----------------
    a_serr_two_clk: assert property (
        (addr_phase && csw_cmd[pci_cmd_pkg::CSW_SERR_EN_BIT]) ##1
        (par != $past(^{ad, c_be_l})) |=> serr_oe_r && !serr_l_r
    ) else $error("serr not two clocks after bad address");
    a_serr_status: assert property (
        $rose(serr_oe_r) |-> sig_sys_err_r && $past(csw_cmd[pci_cmd_pkg::CSW_SERR_EN_BIT])
    ) else $error("serr without status or enable");
    a_rom_select: assert property (
        serial_rom_select_r == $past(rom_access)
    ) else $error("rom select not tracking access");
    a_stop_ends: assert property (
        (m_state_r == pci_cmd_pkg::M_DATA && !stop_l) |=> mst_done_r ##1 !irdy_oe_r
    ) else $error("master did not end on stop");
    a_done_pair: assert property (
        tgt_done_r |-> $past(!trdy_l_r && trdy_oe_r && !irdy_l)
    ) else $error("target phase done without both ready");
    a_issue_mem: assert property (
        (frame_oe_r && $fell(frame_l_r)) |-> (cbe_r == 4'h6 || cbe_r == 4'h7)
    ) else $error("master issued a non memory command");
    a_claim_ok: assert property (
        (addr_phase && t_ok && t_state_r == pci_cmd_pkg::T_IDLE) |=> ##1 devsel_oe_r && !devsel_l_r
    ) else $error("supported command not claimed");
    a_no_claim: assert property (
        (addr_phase && !t_ok && t_state_r == pci_cmd_pkg::T_IDLE) |=> !devsel_oe_r [*2]
    ) else $error("unsupported command claimed");
    a_parity_out: assert property (
        par_oe_r |-> par_r == ^{$past(ad_r), $past(c_be_l)}
    ) else $error("wrong parity driven");
    a_irdy_data: assert property (
        (irdy_oe_r && !irdy_l_r && mst_wr_r) |-> ad_oe_r && ad_r == m_wdata_r
    ) else $error("irdy on write without data");

endmodule // pci_port_command_handshake
